// file: common/pdfm_map.svh
// Offsets, field positions, reset values and timing figures of the
// pin debounce and function map block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PDFM_MAP_SVH
`define PDFM_MAP_SVH

// ************************************************************
// Extended special-function addresses
// ************************************************************
`define PDFM_ADDR_T0      16'hff80
`define PDFM_ADDR_T1      16'hff81
`define PDFM_ADDR_T3      16'hff83
`define PDFM_ADDR_T4      16'hff84
`define PDFM_ADDR_T5      16'hff85
`define PDFM_ADDR_CLKOUT  16'hff8f
`define PDFM_ADDR_PWM0    16'hff90
`define PDFM_ADDR_PWM0C   16'hff91
`define PDFM_ADDR_PWM1    16'hff94
`define PDFM_ADDR_PWM1C   16'hff95
`define PDFM_ADDR_PWM2    16'hff98
`define PDFM_ADDR_PWM2C   16'hff99
`define PDFM_ADDR_PWM3    16'hff9c
`define PDFM_ADDR_TX1     16'hffa0
`define PDFM_ADDR_RX1     16'hffa1
`define PDFM_ADDR_TWCLK   16'hffa2
`define PDFM_ADDR_TWDAT   16'hffa3
`define PDFM_ADDR_SSEL    16'hffa4
`define PDFM_ADDR_SCLK    16'hffa5
`define PDFM_ADDR_SMO     16'hffa6
`define PDFM_ADDR_SMI     16'hffa7
`define PDFM_ADDR_TX2     16'hffa8
`define PDFM_ADDR_RX2     16'hffa9
`define PDFM_ADDR_DBC0    16'hffc0
`define PDFM_ADDR_DBC1    16'hffc1
`define PDFM_ADDR_DBC2    16'hffc2

// ************************************************************
// Fields and reset values
// ************************************************************
`define PDFM_MAP_RESET    8'h37
`define PDFM_MAP_WMASK    8'h37
`define PDFM_DBC_RESET    8'h00
`define PDFM_NUM_MAPS     23
`define PDFM_NUM_OUTS     17
`define PDFM_NUM_DBC      3
`define PDFM_IDX_TX1      13
`define PDFM_IDX_RX1      14
`define PDFM_PRIO_TX1     11

// Map register index of each output function, highest priority first
`define PDFM_PRIO_MAP '{6, 7, 8, 9, 10, 11, 12, 5, 0, 1, 3, 13, 14, 18, 19, 20, 21}

// Tick period minus one for divider codes 00, 01, 10, 11
`define PDFM_DIV1_LAST    6'h00
`define PDFM_DIV4_LAST    6'h03
`define PDFM_DIV16_LAST   6'h0f
`define PDFM_DIV64_LAST   6'h3f

`endif

// file: common/pdfm_pkg.sv
// Types of the pin debounce and function map block.
// Assumes pdfm_map.svh is on the include path.
`include "pdfm_map.svh"

package pdfm_pkg;

    // Function mapping register layout
    typedef struct packed {
        logic [1:0] rsv_hi;
        logic [1:0] port;
        logic       rsv_lo;
        logic [2:0] pin;
    } pdfm_map_t;

    // Debounce register layout
    typedef struct packed {
        logic [1:0] tick_div;
        logic [5:0] tick_count;
    } pdfm_dbc_t;

    // Extended special-function access from the CPU
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } pdfm_xsfr_t;

endpackage : pdfm_pkg

// file: rtl/pdfm_top.sv
// Pin debounce filters for port 0 pins 0..2 and the peripheral function
// crossbar over ports 0..3, with its mapping registers in extended SFR space.
// Assumes pad enables come from the port mode registers on the same clock
// and that pad inputs are asynchronous.
`timescale 1ns/100ps
`default_nettype none
`include "pdfm_map.svh"

module pdfm_top
    import pdfm_pkg::*;
#(
    parameter int NUM_PINS = 32
)
(
    input  wire logic                      CLK,
    input  wire logic                      RSTN,
    input  wire pdfm_xsfr_t                XSFR,
    output logic [7:0]                     XRDATA,
    input  wire logic [NUM_PINS-1:0]       PIN_IN,
    input  wire logic [NUM_PINS-1:0]       PAD_OUT_EN,
    input  wire logic [NUM_PINS-1:0]       PORT_DATA,
    output logic [NUM_PINS-1:0]            PIN_OUT,
    output logic [NUM_PINS-1:0]            PIN_LEVEL,
    input  wire logic [`PDFM_NUM_OUTS-1:0] FUNC_OUT,
    output logic [`PDFM_NUM_MAPS-1:0]      FUNC_IN
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (NUM_PINS != 32)
    begin : g_bad_pins
        $error("NUM_PINS must be 32: two port bits and three pin bits");
    end

    localparam int unsigned PRIO_MAP [`PDFM_NUM_OUTS] = `PDFM_PRIO_MAP;
    localparam logic [15:0] MAP_ADDR [`PDFM_NUM_MAPS] = '{
        `PDFM_ADDR_T0, `PDFM_ADDR_T1, `PDFM_ADDR_T3, `PDFM_ADDR_T4,
        `PDFM_ADDR_T5, `PDFM_ADDR_CLKOUT, `PDFM_ADDR_PWM0,
        `PDFM_ADDR_PWM0C, `PDFM_ADDR_PWM1, `PDFM_ADDR_PWM1C,
        `PDFM_ADDR_PWM2, `PDFM_ADDR_PWM2C, `PDFM_ADDR_PWM3,
        `PDFM_ADDR_TX1, `PDFM_ADDR_RX1, `PDFM_ADDR_TWCLK,
        `PDFM_ADDR_TWDAT, `PDFM_ADDR_SSEL, `PDFM_ADDR_SCLK,
        `PDFM_ADDR_SMO, `PDFM_ADDR_SMI, `PDFM_ADDR_TX2, `PDFM_ADDR_RX2};
    localparam logic [15:0] DBC_ADDR [`PDFM_NUM_DBC] = '{
        `PDFM_ADDR_DBC0, `PDFM_ADDR_DBC1, `PDFM_ADDR_DBC2};

    // ************************************************************
    // Helpers
    // ************************************************************
    // Flat pin number of a mapping register
    function automatic logic [4:0] map_target(input pdfm_map_t m);
        map_target = {m.port, m.pin};
    endfunction : map_target

    // Last prescaler value of one debounce tick
    function automatic logic [5:0] tick_last(input logic [1:0] code);
        logic [5:0] r;
        unique case (code)
            2'b00:   r = `PDFM_DIV1_LAST;
            2'b01:   r = `PDFM_DIV4_LAST;
            2'b10:   r = `PDFM_DIV16_LAST;
            2'b11:   r = `PDFM_DIV64_LAST;
        endcase
        tick_last = r;
    endfunction : tick_last

    // ************************************************************
    // Registers and bus decode
    // ************************************************************
    pdfm_map_t                    map_reg [`PDFM_NUM_MAPS];
    pdfm_dbc_t                    dbc_reg [`PDFM_NUM_DBC];
    logic [`PDFM_NUM_MAPS-1:0]    map_hit;
    logic [`PDFM_NUM_DBC-1:0]     dbc_hit;
    logic [7:0]                   rd_next;
    logic [7:0]                   xrdata_reg;

    // Only the external-data port reaches these registers
    always_comb
    begin
        rd_next = 8'h00;
        for (int i = 0; i < `PDFM_NUM_MAPS; i++)
        begin
            map_hit[i] = (XSFR.addr == MAP_ADDR[i]);
            if (map_hit[i])
                rd_next = map_reg[i] & `PDFM_MAP_WMASK;
        end
        for (int i = 0; i < `PDFM_NUM_DBC; i++)
        begin
            dbc_hit[i] = (XSFR.addr == DBC_ADDR[i]);
            if (dbc_hit[i])
                rd_next = dbc_reg[i];
        end
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            for (int i = 0; i < `PDFM_NUM_MAPS; i++)
                map_reg[i] <= `PDFM_MAP_RESET;
            for (int i = 0; i < `PDFM_NUM_DBC; i++)
                dbc_reg[i] <= `PDFM_DBC_RESET;
            xrdata_reg <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < `PDFM_NUM_MAPS; i++)
                if (XSFR.wr && map_hit[i])
                    map_reg[i] <= XSFR.wdata & `PDFM_MAP_WMASK;
            for (int i = 0; i < `PDFM_NUM_DBC; i++)
                if (XSFR.wr && dbc_hit[i])
                    dbc_reg[i] <= XSFR.wdata;
            if (XSFR.rd)
                xrdata_reg <= rd_next;
        end
    end

    assign XRDATA = xrdata_reg;

    // ************************************************************
    // Pad input synchroniser
    // ************************************************************
    logic [NUM_PINS-1:0] sync1_reg;
    logic [NUM_PINS-1:0] sync2_reg;

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= PIN_IN;
            sync2_reg <= sync1_reg;
        end
    end

    // ************************************************************
    // Debounce filters on port 0 pins 0..2
    // ************************************************************
    // The prescaler restarts on each candidate edge so the hold time is
    // exactly count ticks; a free-running divider would add jitter.
    logic [5:0]               presc_reg [`PDFM_NUM_DBC];
    logic [5:0]               ticks_reg [`PDFM_NUM_DBC];
    logic [`PDFM_NUM_DBC-1:0] stable_reg;
    logic [`PDFM_NUM_DBC-1:0] differs;
    logic [`PDFM_NUM_DBC-1:0] tick;
    logic [`PDFM_NUM_DBC-1:0] accept;
    logic [`PDFM_NUM_DBC-1:0] bypass;

    always_comb
    begin
        for (int i = 0; i < `PDFM_NUM_DBC; i++)
        begin
            bypass[i]  = (dbc_reg[i].tick_count == 6'h00);
            differs[i] = (sync2_reg[i] != stable_reg[i]);
            tick[i]    = differs[i] &&
                         (presc_reg[i] == tick_last(dbc_reg[i].tick_div));
            accept[i]  = tick[i] &&
                         (ticks_reg[i] + 6'h01 == dbc_reg[i].tick_count);
        end
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            for (int i = 0; i < `PDFM_NUM_DBC; i++)
            begin
                presc_reg[i] <= 6'h00;
                ticks_reg[i] <= 6'h00;
            end
            stable_reg <= '0;
        end
        else
        begin
            for (int i = 0; i < `PDFM_NUM_DBC; i++)
            begin
                if (bypass[i] || !differs[i] || accept[i])
                begin
                    // A glitch shorter than the hold time lands here
                    presc_reg[i] <= 6'h00;
                    ticks_reg[i] <= 6'h00;
                end
                else if (tick[i])
                begin
                    presc_reg[i] <= 6'h00;
                    ticks_reg[i] <= ticks_reg[i] + 6'h01;
                end
                else
                    presc_reg[i] <= presc_reg[i] + 6'h01;
                if (bypass[i] || accept[i])
                    stable_reg[i] <= sync2_reg[i];
            end
        end
    end

    // Filtered level feeds port reads and the input crossbar
    logic [NUM_PINS-1:0] level;
    assign level = {sync2_reg[NUM_PINS-1:`PDFM_NUM_DBC], stable_reg};

    // ************************************************************
    // Output crossbar
    // ************************************************************
    logic [NUM_PINS-1:0] pin_out_next;
    logic [NUM_PINS-1:0] pin_owned;

    always_comb
    begin
        pin_out_next = PORT_DATA;
        pin_owned    = '0;
        // Lowest priority first so the highest one writes last
        for (int f = `PDFM_NUM_OUTS - 1; f >= 0; f--)
        begin
            pin_out_next[map_target(map_reg[PRIO_MAP[f]])] = FUNC_OUT[f];
            pin_owned[map_target(map_reg[PRIO_MAP[f]])]    = 1'b1;
        end
    end

    // ************************************************************
    // Input crossbar
    // ************************************************************
    logic [`PDFM_NUM_MAPS-1:0] func_in_next;
    logic [4:0]                tx_pin;
    logic                      tx_rx_join;

    assign tx_pin     = map_target(map_reg[`PDFM_IDX_TX1]);
    assign tx_rx_join = (tx_pin == map_target(map_reg[`PDFM_IDX_RX1])) &&
                        PAD_OUT_EN[tx_pin];

    always_comb
    begin
        for (int i = 0; i < `PDFM_NUM_MAPS; i++)
            func_in_next[i] = level[map_target(map_reg[i])];
        if (tx_rx_join)
            func_in_next[`PDFM_IDX_RX1] = FUNC_OUT[`PDFM_PRIO_TX1];
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            PIN_OUT   <= '0;
            PIN_LEVEL <= '0;
            FUNC_IN   <= '0;
        end
        else
        begin
            PIN_OUT   <= pin_out_next;
            PIN_LEVEL <= level;
            FUNC_IN   <= func_in_next;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    AST_DIV4_TICK: assert property (
        differs[0] && !bypass[0] && dbc_reg[0].tick_div == 2'b01 && tick[0]
        |-> presc_reg[0] == 6'h03)
        else $error("Divide-by-4 tick at wrong prescale");

    AST_BYPASS: assert property (
        bypass[1] && $stable(bypass[1]) |=> stable_reg[1] == $past(sync2_reg[1]))
        else $error("Zero count did not pass input through");

    // A count of one at divide-by-1 legally accepts a one-cycle pulse
    AST_GLITCH: assert property (
        !bypass[0] && dbc_reg[0] != 8'h01 && !differs[0]
        ##1 differs[0] && $stable(dbc_reg[0]) ##1 !differs[0]
        |-> $stable(stable_reg[0]))
        else $error("Short pulse accepted");

    AST_HOLD_TIME: assert property (
        $rose(differs[2]) && dbc_reg[2] == 8'h03 && $stable(dbc_reg[2])
        ##1 differs[2] [*2] |=> stable_reg[2] == $past(sync2_reg[2]))
        else $error("Count of 3 at divide-by-1 not accepted on time");

    AST_RESET_MAP: assert property (
        $rose(RSTN) |-> map_reg[0] == `PDFM_MAP_RESET)
        else $error("Mapping register reset value wrong");

    AST_PRIO: assert property (
        1'b1 |=>
        PIN_OUT[$past(map_target(map_reg[PRIO_MAP[0]]))] == $past(FUNC_OUT[0]))
        else $error("Top priority output lost on its pin");

    AST_GPIO: assert property (
        !pin_owned[1] |=> PIN_OUT[1] == $past(PORT_DATA[1]))
        else $error("Unowned pin not driven from port data");

    AST_MULTI_IN: assert property (
        map_reg[0] == map_reg[4] |=> FUNC_IN[0] == FUNC_IN[4])
        else $error("Shared input pin not fed to both functions");

    AST_JOIN: assert property (
        tx_rx_join |=> FUNC_IN[`PDFM_IDX_RX1] == $past(FUNC_OUT[`PDFM_PRIO_TX1]))
        else $error("Transmit not looped to receive");

    AST_LEVEL: assert property (
        ##1 1'b1 |-> PIN_LEVEL[20] == $past(sync2_reg[20]))
        else $error("Port read differs from pin level");

    AST_READBACK: assert property (
        XSFR.wr && map_hit[13] ##1 XSFR.rd && map_hit[13] && !XSFR.wr
        |=> XRDATA == ($past(XSFR.wdata, 2) & `PDFM_MAP_WMASK))
        else $error("Mapping register readback wrong");

    COV_ACCEPT: cover property (accept[0] && !bypass[0]);
    COV_CONFLICT: cover property (pin_owned[0] &&
        map_reg[5] == map_reg[3] && map_reg[5] == 8'h01);
    COV_JOIN: cover property (tx_rx_join);

endmodule : pdfm_top
`default_nettype wire

// file: sim/pdfm_partner.sv
// Model of the pads and of the peripheral blocks around the function crossbar.
// Assumes the bench sets the outside pin levels and the peripheral output values.
`timescale 1ns/100ps
`default_nettype none

module pdfm_partner
    import pdfm_pkg::*;
(
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pad_out_en,
    input  wire logic [31:0] ext_level,
    input  wire logic [16:0] func_val,
    output logic      [31:0] pin_in,
    output logic      [16:0] func_out
);
    // ************************************************************
    // Pad resolution
    // ************************************************************
    // A driven pad reads back its own output, so a port read sees the real wire
    assign pin_in   = (pad_out_en & pin_out) | (~pad_out_en & ext_level);
    assign func_out = func_val;

endmodule : pdfm_partner

`default_nettype wire

// file: sim/tb_pin_debounce_and_function_map.sv
// Self-checking bench for the debounce filters and the function crossbar.
// Assumes pdfm_top with 32 pins and the partner model beside it.
`timescale 1ns/100ps
`default_nettype none
`include "pdfm_map.svh"

module tb_pin_debounce_and_function_map
    import pdfm_pkg::*;
;
    logic       CLK;
    logic       RSTN;
    pdfm_xsfr_t xsfr;
    logic [7:0]  xrdata;
    logic [31:0] pin_in, pad_out_en, port_data, pin_out, pin_level, ext_level, e, seed;
    logic [16:0] func_val, func_out;
    logic [22:0] func_in;
    logic [7:0]  exp_q[$];
    logic        rd_d1, rd_d2, seen;
    logic [2:0]  pn;
    int          n_fail, checks_done, n;
    localparam logic [15:0] MAP_ADDR [23] = '{`PDFM_ADDR_T0, `PDFM_ADDR_T1, `PDFM_ADDR_T3,
        `PDFM_ADDR_T4, `PDFM_ADDR_T5, `PDFM_ADDR_CLKOUT, `PDFM_ADDR_PWM0, `PDFM_ADDR_PWM0C,
        `PDFM_ADDR_PWM1, `PDFM_ADDR_PWM1C, `PDFM_ADDR_PWM2, `PDFM_ADDR_PWM2C, `PDFM_ADDR_PWM3,
        `PDFM_ADDR_TX1, `PDFM_ADDR_RX1, `PDFM_ADDR_TWCLK, `PDFM_ADDR_TWDAT, `PDFM_ADDR_SSEL,
        `PDFM_ADDR_SCLK, `PDFM_ADDR_SMO, `PDFM_ADDR_SMI, `PDFM_ADDR_TX2, `PDFM_ADDR_RX2};

    pdfm_top pdfm_top_i (.CLK(CLK), .RSTN(RSTN), .XSFR(xsfr), .XRDATA(xrdata),
        .PIN_IN(pin_in), .PAD_OUT_EN(pad_out_en), .PORT_DATA(port_data),
        .PIN_OUT(pin_out), .PIN_LEVEL(pin_level), .FUNC_OUT(func_out), .FUNC_IN(func_in));
    pdfm_partner pdfm_partner_i (.pin_out(pin_out), .pad_out_en(pad_out_en),
        .ext_level(ext_level), .func_val(func_val), .pin_in(pin_in), .func_out(func_out));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    // Strobes idle one cycle at the end so back-to-back calls never re-raise at once
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        xsfr.addr  = a;
        xsfr.wdata = d;
        xsfr.wr    = 1'b1;
        @(negedge CLK);
        xsfr.wr = 1'b0;
        @(negedge CLK);
    endtask : wr_reg

    task automatic rd_reg(input logic [15:0] a, input logic [7:0] d);
        xsfr.addr = a;
        xsfr.rd   = 1'b1;
        exp_q.push_back(d);
        @(negedge CLK);
        xsfr.rd = 1'b0;
        @(negedge CLK);
    endtask : rd_reg

    task automatic rnd();
        seed      = lfsr(seed);
        port_data = seed;
        seed      = lfsr(seed);
        func_val  = seed[16:0];
    endtask : rnd

    // ************************************************************
    // Clock, read monitor, watchdog
    // ************************************************************
    initial
    begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    always @(posedge CLK)
    begin
        rd_d1 <= xsfr.rd;
        rd_d2 <= rd_d1;
    end

    always @(negedge CLK)
        if (rd_d2 === 1'b1)
            check("XRDATA", exp_q.pop_front(), {24'h0, xrdata});

    initial
    begin
        #200000;
        $display("watchdog expired");
        n_fail++;
        summarize();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial
    begin
        n_fail = 0;
        checks_done = 0;
        seed = 32'h5ee4;
        RSTN = 1'b0;
        xsfr = '0;
        pad_out_en = '0;
        ext_level = '0;
        rnd();
        repeat (3) @(negedge CLK);
        RSTN = 1'b1;
        for (int i = 0; i < 23; i++) rd_reg(MAP_ADDR[i], 8'h37);
        for (int i = 0; i < 3; i++) rd_reg(`PDFM_ADDR_DBC0 + 16'(i), 8'h00);
        rd_reg(16'hff82, 8'h00);
        check("PIN_OUT", {func_val[0], port_data[30:0]}, pin_out);
        wr_reg(`PDFM_ADDR_T3, 8'hc8);
        rd_reg(`PDFM_ADDR_T3, 8'h00);
        seed = lfsr(seed);
        wr_reg(`PDFM_ADDR_DBC2, seed[7:0]);
        rd_reg(`PDFM_ADDR_DBC2, seed[7:0]);
        $display("test registers done");

        for (int p = 0; p < 4; p++)
        begin
            rnd();
            pn = (p == 3 && seed[2:0] == 3'h7) ? 3'h6 : seed[2:0];
            wr_reg(`PDFM_ADDR_CLKOUT, {2'h0, 2'(p), 1'b0, pn});
            e = port_data;
            e[31] = func_val[0];
            e[p * 8 + pn] = func_val[7];
            check("PIN_OUT", e, pin_out);
        end
        $display("test mapping done");

        wr_reg(`PDFM_ADDR_CLKOUT, 8'h01);
        wr_reg(`PDFM_ADDR_T4, 8'h01);
        for (int k = 0; k < 2; k++)
        begin
            rnd();
            func_val[7]  = k[0];
            func_val[10] = ~k[0];
            @(negedge CLK);
            check("PIN_OUT_1", {31'h0, k[0]}, {31'h0, pin_out[1]});
        end
        $display("test priority done");

        wr_reg(`PDFM_ADDR_T0, 8'h23);
        wr_reg(`PDFM_ADDR_T5, 8'h23);
        ext_level[19] = 1'b1;
        repeat (2) @(negedge CLK);
        check("PIN_LEVEL_19", 32'h0, {31'h0, pin_level[19]});
        @(negedge CLK);
        check("PIN_LEVEL_19", 32'h1, {31'h0, pin_level[19]});
        check("FUNC_IN_T0_T5", 32'h3, {30'h0, func_in[4], func_in[0]});
        $display("test input fanout done");

        wr_reg(`PDFM_ADDR_TX1, 8'h21);
        wr_reg(`PDFM_ADDR_RX1, 8'h21);
        pad_out_en[17] = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            func_val[11] = ~func_in[14];
            repeat (2) @(negedge CLK);
            check("FUNC_IN_RX1", {31'h0, func_val[11]}, {31'h0, func_in[14]});
        end
        pad_out_en[17] = 1'b0;
        $display("test transmit receive join done");

        // Pin 0 feeds timer 1 so the filter is seen through the crossbar too
        wr_reg(`PDFM_ADDR_T1, 8'h00);
        for (int c = 0; c < 4; c++)
        begin
            wr_reg(`PDFM_ADDR_DBC0, {2'(c), 6'h02});
            n = 2 << (2 * c);
            ext_level[0] = 1'b1;
            repeat (n - 1) @(negedge CLK);
            ext_level[0] = 1'b0;
            seen = 1'b0;
            repeat (n + 6)
            begin
                @(negedge CLK);
                seen = seen | pin_level[0];
            end
            check("GLITCH_0", 32'h0, {31'h0, seen});
            ext_level[0] = 1'b1;
            repeat (n + 2) @(negedge CLK);
            check("PIN_LEVEL_0", 32'h0, {31'h0, pin_level[0]});
            @(negedge CLK);
            check("PIN_LEVEL_0", 32'h1, {31'h0, pin_level[0]});
            @(negedge CLK);
            check("FUNC_IN_T1", 32'h1, {31'h0, func_in[1]});
            ext_level[0] = 1'b0;
            repeat (n + 8) @(negedge CLK);
        end
        wr_reg(`PDFM_ADDR_DBC0, 8'h00);
        ext_level[0] = 1'b1;
        @(negedge CLK);
        ext_level[0] = 1'b0;
        seen = 1'b0;
        repeat (6)
        begin
            @(negedge CLK);
            seen = seen | pin_level[0];
        end
        check("BYPASS_0", 32'h1, {31'h0, seen});
        $display("test debounce done");
        summarize();
    end

endmodule : tb_pin_debounce_and_function_map

`default_nettype wire
